// ===== rtl/wsm_cfg.svh
// Bit positions, thresholds and counts of the wake status monitor
`ifndef WSM_CFG_SVH
`define WSM_CFG_SVH
// Cause byte and interrupt mask bit positions
`define WSM_BIT_WAKE     7
`define WSM_BIT_ALARM1   6
`define WSM_BIT_ALARM2   5
`define WSM_BIT_ONE_SEC  2
`define WSM_BIT_HALF_SEC 1
// Bits that exist in the cause byte and interrupt mask
`define WSM_CAUSE_USED   8'hE6
// Ring indicator position in the input status byte
`define WSM_BIT_RING     5
// Power-on condition bit positions
`define WSM_PON_RING     0
`define WSM_PON_WAKE     1
`define WSM_PON_PREBEEP  2
`define WSM_PON_CHIME    3
// Only the low nibble of the power-on mask is kept
`define WSM_PON_USED     8'h0F
// Seconds of warning beeps before a timed power-on, minus the first
`define WSM_PREBEEP_LEFT 3'h6
// Supply thresholds
`define WSM_MAIN_LOW     8'hAF
`define WSM_MAIN_OK      8'hBE
`define WSM_PER_LOW      8'hA8
// Reset values
`define WSM_BYTE_RST     8'h00
`define WSM_CNT_RST      3'h0
`endif

// ===== rtl/wsm_lowbat.sv
// Low supply detector with optional hysteresis band
`timescale 1ns/10ps
`include "wsm_cfg.svh"
module wsm_lowbat #(
  parameter logic [7:0] LOW_TH = 8'hA8,     // Declare low below this
  parameter logic [7:0] OK_TH  = 8'hA7      // Release above this
) (
  input  wire logic            core_clk_i,  // System clock
  input  wire logic            rst_i,       // Async reset, high
  input  wire wsm_pkg::wsm_byte_t level_i,  // Digitised supply level
  output logic                 low_o        // Low battery flag
);
  import wsm_pkg::*;

  logic low_q;                              // Flag register
  logic low_d;                              // Flag next value

  // Set below the low mark, clear only above the release mark
  always_comb begin
    low_d = low_q;
    if (level_i < LOW_TH) begin
      low_d = 1'h1;
    end else if (level_i > OK_TH) begin
      low_d = 1'h0;
    end
  end

  // Flag register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_q <= 1'h0;
    end else begin
      low_q <= low_d;
    end
  end

  assign low_o = low_q;
endmodule

// ===== rtl/wsm_monitor.sv
// Wake status and power-on condition monitor, top level
`timescale 1ns/10ps
`include "wsm_cfg.svh"
// Contract
// - Wake bit7, alarm1 bit6, alarm2 bit5 causes.
// - One-second cause bit2, half-second bit1.
// - Cause bit reads one once event occurred.
// - Ring line shown inverted in bit 5.
// - Power-on mask held, bits 7-4 zero.
// - Bit 0 governs ring line switch-on.
// - Bit 1 governs wakeup timer switch-on.
// - Bit 2: seven warning beeps before wake.
// - Bit 3: beep each hour while powered.
// - Power-on mask low nibble reads back as written.
// - Main supply byte, low below AF, release above BE.
// - Peripheral supply byte, low below A8.
// - Analog input readable as one byte.
// - Interrupt mask mirrors cause bits; one suppresses.
module wsm_monitor (
  input  wire logic               core_clk_i,     // System clock
  input  wire logic               rst_i,          // Async reset, high
  // Interrupt sources, one-cycle pulses
  input  wire logic               wake_evt_i,     // Wakeup time reached
  input  wire logic               alarm1_evt_i,   // Alarm1 time reached
  input  wire logic               alarm2_evt_i,   // Alarm2 time reached
  input  wire logic               one_second_tick_i,  // Second tick
  input  wire logic               half_second_tick_i, // Half second
  // Other timing events
  input  wire logic               wake_pre_i,     // Wakeup in 7 s
  input  wire logic               hour_tick_i,    // Top of the hour
  input  wire logic               unit_on_i,      // Unit is powered
  // Cause acknowledge and interrupt mask
  input  wire logic               cause_ack_i,    // Acknowledge strobe
  input  wire wsm_pkg::wsm_byte_t cause_clr_i,    // Bits to clear
  input  wire logic               irq_mask_wr_i,  // Mask write strobe
  input  wire wsm_pkg::wsm_byte_t irq_mask_i,     // Mask write data
  // Power-on condition mask
  input  wire logic               pon_mask_wr_i,  // Mask write strobe
  input  wire wsm_pkg::wsm_byte_t pon_mask_i,     // Mask write data
  // Serial ring indicator line
  input  wire logic               ring_line_i,    // Ring line level
  // Digitised voltages
  input  wire wsm_pkg::wsm_byte_t main_adc_i,     // Main supply
  input  wire wsm_pkg::wsm_byte_t per_adc_i,      // Peripheral battery
  input  wire wsm_pkg::wsm_byte_t ain_adc_i,      // Analog input
  // Readback
  output wsm_pkg::wsm_byte_t      cause_o,        // Cause byte
  output wsm_pkg::wsm_byte_t      irq_mask_o,     // Interrupt mask
  output logic                    irq_req_o,      // Unmasked cause
  output wsm_pkg::wsm_byte_t      ring_stat_o,    // Input status byte
  output wsm_pkg::wsm_byte_t      pon_mask_o,     // Power-on mask
  output wsm_pkg::wsm_byte_t      main_volt_o,    // Main supply byte
  output wsm_pkg::wsm_byte_t      per_volt_o,     // Peripheral byte
  output wsm_pkg::wsm_byte_t      ain_volt_o,     // Analog input byte
  output logic                    main_low_o,     // Main low battery
  output logic                    per_low_o,      // Peripheral low
  // Power-on actions
  output logic                    pon_req_o,      // Switch unit on
  output logic                    beep_o          // Beep request
);
  import wsm_pkg::*;

  // Places one event into its cause bit position
  function automatic wsm_byte_t put_bit(input logic v,
                                        input int unsigned pos);
    wsm_byte_t r;
    r = `WSM_BYTE_RST;
    r[pos[2:0]] = v;
    return r;
  endfunction

  // Cause group
  wsm_byte_t cause_q;                       // Sticky causes
  wsm_byte_t cause_d;                       // Next causes
  wsm_byte_t cause_set;                     // Events this cycle
  wsm_byte_t imask_q;                       // Interrupt mask
  wsm_byte_t imask_d;                       // Next mask
  logic      irq_q;                         // Interrupt request
  logic      irq_d;                         // Next request

  // Ring line group
  logic      ring_prev_q;                   // Ring level last cycle
  logic      ring_prev_d;                   // Next ring level
  wsm_byte_t ring_stat_q;                   // Status byte
  wsm_byte_t ring_stat_d;                   // Next status byte
  logic      ring_event;                    // Line fell this cycle

  // Power-on mask group
  wsm_byte_t pon_q;                         // Power-on mask
  wsm_byte_t pon_d;                         // Next mask

  // Voltage group
  wsm_byte_t main_q;                        // Main supply byte
  wsm_byte_t main_d;                        // Next main byte
  wsm_byte_t per_q;                         // Peripheral byte
  wsm_byte_t per_d;                         // Next peripheral byte
  wsm_byte_t ain_q;                         // Analog byte
  wsm_byte_t ain_d;                         // Next analog byte

  // Sequencer link
  wsm_seq_if sq ();                         // Top to sequencer

  // Gather the five sources into cause positions
  always_comb begin
    cause_set = put_bit(wake_evt_i,   `WSM_BIT_WAKE)
              | put_bit(alarm1_evt_i, `WSM_BIT_ALARM1)
              | put_bit(alarm2_evt_i, `WSM_BIT_ALARM2)
              | put_bit(one_second_tick_i,  `WSM_BIT_ONE_SEC)
              | put_bit(half_second_tick_i, `WSM_BIT_HALF_SEC);
  end

  // Cause and mask next values
  always_comb begin
    cause_d = cause_q;
    imask_d = imask_q;
    // Acknowledge clears chosen bits only
    if (cause_ack_i) begin
      cause_d = cause_d & ~cause_clr_i;
    end
    // New events win over a clear, mask does not matter
    cause_d = (cause_d | cause_set) & `WSM_CAUSE_USED;
    // Interrupt mask keeps only the cause positions
    if (irq_mask_wr_i) begin
      imask_d = irq_mask_i & `WSM_CAUSE_USED;
    end
    // Request while any unmasked cause stands
    irq_d = |(cause_d & ~imask_d);
  end

  // Cause and mask registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q <= `WSM_BYTE_RST;
      imask_q <= `WSM_BYTE_RST;
      irq_q   <= 1'h0;
    end else begin
      cause_q <= cause_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
    end
  end

  // Ring line status and falling edge
  always_comb begin
    ring_prev_d = ring_line_i;
    // Low line reads one, high line reads zero
    ring_stat_d = put_bit(~ring_line_i, `WSM_BIT_RING);
  end

  // Edge of the ring line turning active
  assign ring_event = ring_prev_q & ~ring_line_i;

  // Ring line registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_prev_q <= 1'h1;
      ring_stat_q <= `WSM_BYTE_RST;
    end else begin
      ring_prev_q <= ring_prev_d;
      ring_stat_q <= ring_stat_d;
    end
  end

  // Power-on mask next value
  always_comb begin
    pon_d = pon_q;
    if (pon_mask_wr_i) begin
      // Upper nibble always held at zero
      pon_d = pon_mask_i & `WSM_PON_USED;
    end
  end

  // Power-on mask register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pon_q <= `WSM_BYTE_RST;
    end else begin
      pon_q <= pon_d;
    end
  end

  // Voltage sampling, one byte each
  always_comb begin
    main_d = main_adc_i;
    per_d  = per_adc_i;
    ain_d  = ain_adc_i;
  end

  // Voltage registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_q <= `WSM_BYTE_RST;
      per_q  <= `WSM_BYTE_RST;
      ain_q  <= `WSM_BYTE_RST;
    end else begin
      main_q <= main_d;
      per_q  <= per_d;
      ain_q  <= ain_d;
    end
  end

  // Main supply with hysteresis band
  wsm_lowbat #(
    .LOW_TH (`WSM_MAIN_LOW),
    .OK_TH  (`WSM_MAIN_OK)
  ) u_main_low (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .level_i    (main_q),
    .low_o      (main_low_o)
  );

  // Peripheral battery, plain threshold
  wsm_lowbat #(
    .LOW_TH (`WSM_PER_LOW),
    .OK_TH  (`WSM_PER_LOW - 8'h01)
  ) u_per_low (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .level_i    (per_q),
    .low_o      (per_low_o)
  );

  // Feed the sequencer
  assign sq.sec_tick   = one_second_tick_i;
  assign sq.hour_tick  = hour_tick_i;
  assign sq.wake_pre   = wake_pre_i;
  assign sq.wake_hit   = wake_evt_i;
  assign sq.ring_event = ring_event;
  assign sq.unit_on    = unit_on_i;
  assign sq.pon_bits   = pon_q[3:0];

  // Switch-on and beep sequencing
  wsm_pwr_seq u_seq (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .sq         (sq.seq)
  );

  // Readback ports, all from registers
  assign cause_o     = cause_q;
  assign irq_mask_o  = imask_q;
  assign irq_req_o   = irq_q;
  assign ring_stat_o = ring_stat_q;
  assign pon_mask_o  = pon_q;
  assign main_volt_o = main_q;
  assign per_volt_o  = per_q;
  assign ain_volt_o  = ain_q;
  assign pon_req_o   = sq.pon_req;
  assign beep_o      = sq.beep;
endmodule

// ===== rtl/wsm_pkg.sv
// Shared types of the wake status monitor
package wsm_pkg;
  typedef logic [7:0] wsm_byte_t;           // One status or data byte
  typedef logic [3:0] wsm_pon_t;            // Kept power-on condition bits
  typedef enum logic [0:0] {
    WSM_SEQ_IDLE,                           // No timed power-on warning
    WSM_SEQ_WARN                            // Counting warning beeps
  } wsm_seq_state_t;
endpackage

// ===== rtl/wsm_pwr_seq.sv
// Power-on conditions: ring and timer switch-on, warning beeps, chime
`timescale 1ns/10ps
`include "wsm_cfg.svh"
module wsm_pwr_seq (
  input  wire logic core_clk_i,             // System clock
  input  wire logic rst_i,                  // Async reset, high
  wsm_seq_if.seq    sq                      // Link to the top
);
  import wsm_pkg::*;

  wsm_seq_state_t state_q;                  // Sequencer state
  wsm_seq_state_t state_d;                  // Next state
  logic [2:0]     left_q;                   // Warning beeps still due
  logic [2:0]     left_d;                   // Next count
  logic           beep_q;                   // Beep pulse register
  logic           beep_d;                   // Next beep
  logic           pon_q;                    // Switch-on pulse register
  logic           pon_d;                    // Next switch-on
  logic           wake_ok;                  // Timer may switch on

  assign wake_ok = sq.pon_bits[`WSM_PON_WAKE] & ~sq.unit_on;

  // Next state, beeps and switch-on requests
  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    beep_d  = 1'h0;
    pon_d   = 1'h0;
    // Ring line event switches the unit on when allowed
    if (sq.ring_event && sq.pon_bits[`WSM_PON_RING] && !sq.unit_on) begin
      pon_d = 1'h1;
    end
    // Wakeup time reached switches the unit on when allowed
    if (sq.wake_hit && wake_ok) begin
      pon_d = 1'h1;
    end
    // Hourly chime only while powered
    if (sq.hour_tick && sq.unit_on && sq.pon_bits[`WSM_PON_CHIME]) begin
      beep_d = 1'h1;
    end
    case (state_q)
      WSM_SEQ_IDLE: begin
        // First warning beep seven seconds ahead of a timed switch-on
        if (sq.wake_pre && wake_ok && sq.pon_bits[`WSM_PON_PREBEEP]) begin
          beep_d  = 1'h1;
          left_d  = `WSM_PREBEEP_LEFT;
          state_d = WSM_SEQ_WARN;
        end
      end
      WSM_SEQ_WARN: begin
        // One beep on each following second tick
        // Stop when the time arrives or a condition is withdrawn
        if (sq.wake_hit || !wake_ok || !sq.pon_bits[`WSM_PON_PREBEEP]) begin
          state_d = WSM_SEQ_IDLE;
          left_d  = `WSM_CNT_RST;
        end else if (sq.sec_tick) begin
          beep_d = 1'h1;
          left_d = left_q - 3'h1;
          if (left_q == 3'h1) begin
            state_d = WSM_SEQ_IDLE;
          end
        end
      end
      default: begin
        state_d = WSM_SEQ_IDLE;
        left_d  = `WSM_CNT_RST;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= WSM_SEQ_IDLE;
      left_q  <= `WSM_CNT_RST;
      beep_q  <= 1'h0;
      pon_q   <= 1'h0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
      beep_q  <= beep_d;
      pon_q   <= pon_d;
    end
  end

  assign sq.beep    = beep_q;
  assign sq.pon_req = pon_q;
endmodule

// ===== rtl/wsm_seq_if.sv
// Signals between the monitor top and its power-on sequencer
`timescale 1ns/10ps
interface wsm_seq_if;
  logic                  sec_tick;    // One-second tick pulse
  logic                  hour_tick;   // Top of hour pulse
  logic                  wake_pre;    // Wakeup time seven seconds away
  logic                  wake_hit;    // Wakeup time reached
  logic                  ring_event;  // Ring indicator became active
  logic                  unit_on;     // Unit is powered
  wsm_pkg::wsm_pon_t     pon_bits;    // Power-on condition bits
  logic                  beep;        // Beep request pulse
  logic                  pon_req;     // Switch-on request pulse
  modport ctrl (
    output sec_tick, hour_tick, wake_pre, wake_hit, ring_event,
    output unit_on, pon_bits,
    input  beep, pon_req
  );
  modport seq (
    input  sec_tick, hour_tick, wake_pre, wake_hit, ring_event,
    input  unit_on, pon_bits,
    output beep, pon_req
  );
endinterface

// ===== sim/tb_wsm_monitor.sv
// Self-checking bench for the wake status monitor
`timescale 1ns/10ps
bind wsm_monitor wsm_monitor_asserts u_chk (.core_clk_i, .rst_i,
  .wake_evt_i, .alarm1_evt_i, .alarm2_evt_i, .one_second_tick_i,
  .half_second_tick_i, .wake_pre_i, .hour_tick_i, .unit_on_i,
  .cause_ack_i, .cause_clr_i, .pon_mask_wr_i, .pon_mask_i, .ring_line_i,
  .main_adc_i, .ain_adc_i, .cause_o, .irq_mask_o, .irq_req_o,
  .ring_stat_o, .pon_mask_o, .main_volt_o, .per_volt_o, .ain_volt_o,
  .main_low_o, .per_low_o, .pon_req_o, .beep_o);
module tb_wsm_monitor;
  import wsm_pkg::*;
  logic      core_clk_i, rst_i, unit_on_i, ring_line_i;   // Control
  logic      wake_evt_i, alarm1_evt_i, alarm2_evt_i;      // Sources
  logic      one_second_tick_i, half_second_tick_i;       // Ticks
  logic      wake_pre_i, hour_tick_i, cause_ack_i;        // Strobes
  logic      irq_mask_wr_i, pon_mask_wr_i;                // Writes
  wsm_byte_t cause_clr_i, irq_mask_i, pon_mask_i;         // Data
  wsm_byte_t main_adc_i, per_adc_i, ain_adc_i;            // Levels
  wsm_byte_t cause_o, irq_mask_o, ring_stat_o, pon_mask_o; // Readback
  wsm_byte_t main_volt_o, per_volt_o, ain_volt_o;         // Voltages
  logic      irq_req_o, main_low_o, per_low_o;            // Flags
  logic      pon_req_o, beep_o;                           // Pulses
  int        n_fail, tests_run, n_beep, n_pon, b0;        // Counters
  wsm_byte_t exp;                                         // Expected
  int        pos[5] = '{7, 6, 5, 2, 1};                   // Cause bits
  wsm_monitor u_dut (.core_clk_i, .rst_i, .wake_evt_i, .alarm1_evt_i,
    .alarm2_evt_i, .one_second_tick_i, .half_second_tick_i, .wake_pre_i,
    .hour_tick_i, .unit_on_i, .cause_ack_i, .cause_clr_i, .irq_mask_wr_i,
    .irq_mask_i, .pon_mask_wr_i, .pon_mask_i, .ring_line_i, .main_adc_i,
    .per_adc_i, .ain_adc_i, .cause_o, .irq_mask_o, .irq_req_o,
    .ring_stat_o, .pon_mask_o, .main_volt_o, .per_volt_o, .ain_volt_o,
    .main_low_o, .per_low_o, .pon_req_o, .beep_o);
  // Clock generator
  initial begin
    core_clk_i = 1'h0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Pulse counters, sampled at each rising edge
  always @(posedge core_clk_i) begin
    if (beep_o === 1'h1) n_beep++;
    if (pon_req_o === 1'h1) n_pon++;
  end
  // Compare and report
  task automatic check(input wsm_byte_t seen, input wsm_byte_t want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // Counts and verdict
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Drive one strobe with its data
  task automatic set(input int k, input logic v, input wsm_byte_t d);
    case (k)
      0: wake_evt_i <= v;
      1: alarm1_evt_i <= v;
      2: alarm2_evt_i <= v;
      3: one_second_tick_i <= v;
      4: half_second_tick_i <= v;
      5: wake_pre_i <= v;
      6: hour_tick_i <= v;
      7: begin cause_ack_i <= v; cause_clr_i <= d; end
      8: begin irq_mask_wr_i <= v; irq_mask_i <= d; end
      default: begin pon_mask_wr_i <= v; pon_mask_i <= d; end
    endcase
  endtask
  // One-cycle strobe, returns once the result is visible
  task automatic strobe(input int k, input wsm_byte_t d);
    @(posedge core_clk_i);
    set(k, 1'h1, d);
    @(posedge core_clk_i);
    set(k, 1'h0, d);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    static wsm_byte_t mv[5] = '{8'hC0, 8'hAF, 8'hAE, 8'hBE, 8'hBF};
    static wsm_byte_t ml[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    static wsm_byte_t pv[5] = '{8'hA8, 8'hA7, 8'hA9, 8'h00, 8'hFF};
    static wsm_byte_t av[5] = '{8'h00, 8'h5A, 8'hA5, 8'hFF, 8'h01};
    {wake_evt_i, alarm1_evt_i, alarm2_evt_i, one_second_tick_i} = 4'h0;
    {half_second_tick_i, wake_pre_i, hour_tick_i, cause_ack_i} = 4'h0;
    {irq_mask_wr_i, pon_mask_wr_i, unit_on_i} = 3'h0;
    {cause_clr_i, irq_mask_i, pon_mask_i} = 24'h0;
    {main_adc_i, per_adc_i, ain_adc_i} = 24'hC0C000;
    ring_line_i = 1'h1;
    rst_i = 1'h1;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'h0;
    tick(2);
    check(cause_o, 8'h00);
    check(pon_mask_o, 8'h00);
    // Every source sets its own bit, bits stay until cleared
    exp = 8'h00;
    foreach (pos[i]) begin
      strobe(i, 8'h00);
      exp = exp | (8'h01 << pos[i]);
      check(cause_o, exp);
    end
    tick(4);
    check(cause_o, 8'hE6);
    strobe(8, 8'hFF);
    check(irq_mask_o, 8'hE6);
    check({7'h0, irq_req_o}, 8'h00);
    strobe(7, 8'h80);
    check(cause_o, 8'h66);
    strobe(8, 8'hBF);
    check({7'h0, irq_req_o}, 8'h01);
    strobe(7, 8'hFF);
    check(cause_o, 8'h00);
    // Event and clear in the same cycle: the event wins
    @(posedge core_clk_i);
    set(0, 1'h1, 8'h00);
    set(7, 1'h1, 8'h80);
    @(posedge core_clk_i);
    set(0, 1'h0, 8'h00);
    set(7, 1'h0, 8'h80);
    tick(1);
    check(cause_o, 8'h80);
    $display("test causes done");
    // Power-on mask keeps the low nibble only
    strobe(9, 8'hFF);
    check(pon_mask_o, 8'h0F);
    strobe(9, 8'hA5);
    check(pon_mask_o, 8'h05);
    // Ring line falls while switch-on allowed, then while masked
    b0 = n_pon;
    @(posedge core_clk_i);
    ring_line_i <= 1'h0;
    tick(1);
    check(ring_stat_o, 8'h20);
    tick(2);
    check(8'(n_pon - b0), 8'h01);
    @(posedge core_clk_i);
    ring_line_i <= 1'h1;
    tick(2);
    check(ring_stat_o, 8'h00);
    strobe(9, 8'h00);
    @(posedge core_clk_i);
    ring_line_i <= 1'h0;
    tick(3);
    check(8'(n_pon - b0), 8'h01);
    $display("test ring done");
    // Wakeup switch-on allowed, then not
    strobe(8, 8'h80);
    check(irq_mask_o, 8'h80);
    strobe(9, 8'h02);
    strobe(0, 8'h00);
    tick(2);
    check(8'(n_pon - b0), 8'h02);
    strobe(9, 8'h00);
    strobe(0, 8'h00);
    tick(2);
    check(8'(n_pon - b0), 8'h02);
    // Seven warning beeps, none with the beep bit clear
    strobe(9, 8'h06);
    b0 = n_beep;
    strobe(5, 8'h00);
    repeat (8) begin
      tick(3);
      strobe(3, 8'h00);
    end
    tick(2);
    check(8'(n_beep - b0), 8'h07);
    strobe(9, 8'h02);
    strobe(5, 8'h00);
    repeat (2) strobe(3, 8'h00);
    tick(2);
    check(8'(n_beep - b0), 8'h07);
    // Hourly chime only while powered
    strobe(9, 8'h08);
    @(posedge core_clk_i);
    unit_on_i <= 1'h1;
    strobe(6, 8'h00);
    tick(2);
    check(8'(n_beep - b0), 8'h08);
    @(posedge core_clk_i);
    unit_on_i <= 1'h0;
    strobe(6, 8'h00);
    tick(2);
    check(8'(n_beep - b0), 8'h08);
    $display("test power-on done");
    // Supply and analog bytes with low flags
    foreach (mv[i]) begin
      @(posedge core_clk_i);
      main_adc_i <= mv[i];
      per_adc_i <= pv[i];
      ain_adc_i <= av[i];
      tick(4);
      check(main_volt_o, mv[i]);
      check({7'h0, main_low_o}, ml[i]);
      check(per_volt_o, pv[i]);
      check({7'h0, per_low_o}, {7'h0, pv[i] < 8'hA8});
      check(ain_volt_o, av[i]);
    end
    $display("test voltages done");
    results();
  end
endmodule

// ===== sim/wsm_monitor_asserts.sv
// Port-level assertions for the wake status monitor
`timescale 1ns/10ps
module wsm_monitor_asserts (
  input wire logic               core_clk_i,         // Clock
  input wire logic               rst_i,              // Reset
  input wire logic               wake_evt_i,         // Wake event
  input wire logic               alarm1_evt_i,       // Alarm1 event
  input wire logic               alarm2_evt_i,       // Alarm2 event
  input wire logic               one_second_tick_i,  // Second tick
  input wire logic               half_second_tick_i, // Half tick
  input wire logic               wake_pre_i,         // Warning start
  input wire logic               hour_tick_i,        // Hour tick
  input wire logic               unit_on_i,          // Powered
  input wire logic               cause_ack_i,        // Acknowledge
  input wire wsm_pkg::wsm_byte_t cause_clr_i,        // Clear bits
  input wire logic               pon_mask_wr_i,      // Mask write
  input wire wsm_pkg::wsm_byte_t pon_mask_i,         // Mask data
  input wire logic               ring_line_i,        // Ring line
  input wire wsm_pkg::wsm_byte_t main_adc_i,         // Main input
  input wire wsm_pkg::wsm_byte_t ain_adc_i,          // Analog input
  input wire wsm_pkg::wsm_byte_t cause_o,            // Causes
  input wire wsm_pkg::wsm_byte_t irq_mask_o,         // Irq mask
  input wire logic               irq_req_o,          // Irq request
  input wire wsm_pkg::wsm_byte_t ring_stat_o,        // Ring status
  input wire wsm_pkg::wsm_byte_t pon_mask_o,         // Power-on mask
  input wire wsm_pkg::wsm_byte_t main_volt_o,        // Main byte
  input wire wsm_pkg::wsm_byte_t per_volt_o,         // Periph byte
  input wire wsm_pkg::wsm_byte_t ain_volt_o,         // Analog byte
  input wire logic               main_low_o,         // Main low
  input wire logic               per_low_o,          // Periph low
  input wire logic               pon_req_o,          // Switch-on
  input wire logic               beep_o              // Beep
);
  import wsm_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Ring line falls with switch-on allowed
  sequence ring_fall_s;
    ring_line_i ##1 (!ring_line_i && pon_mask_o[0] && !unit_on_i);
  endsequence
  // Warning period begins with beeps allowed
  sequence warn_start_s;
    wake_pre_i && (&pon_mask_o[2:1]) && !unit_on_i;
  endsequence
  // Each source sets its cause bit
  wake_cause_a: assert property (wake_evt_i |=> cause_o[7])
    else $error("wake cause missing");
  alarm_cause_a: assert property (alarm1_evt_i |=> cause_o[6])
    else $error("alarm1 cause missing");
  alarm2_cause_a: assert property (alarm2_evt_i |=> cause_o[5])
    else $error("alarm2 cause missing");
  tick_cause_a: assert property (one_second_tick_i |=> cause_o[2])
    else $error("second cause missing");
  half_cause_a: assert property (half_second_tick_i |=> cause_o[1])
    else $error("half cause missing");
  // Causes only drop where acknowledged
  cause_hold_a: assert property (1'h1 |=> ((cause_o & $past(cause_o &
    ~(cause_ack_i ? cause_clr_i : 8'h00))) == $past(cause_o &
    ~(cause_ack_i ? cause_clr_i : 8'h00))))
    else $error("cause lost");
  unused_zero_a: assert property ((cause_o & 8'h19) == 8'h00 &&
    pon_mask_o[7:4] == 4'h0)
    else $error("unused bit set");
  irq_mirror_a: assert property (irq_req_o == |(cause_o & ~irq_mask_o))
    else $error("irq request wrong");
  ring_inv_a: assert property (!$past(rst_i) |-> ring_stat_o ==
    {2'h0, ~$past(ring_line_i), 5'h00})
    else $error("ring status wrong");
  pon_readback_a: assert property (pon_mask_wr_i |=>
    pon_mask_o == ($past(pon_mask_i) & 8'h0F))
    else $error("power-on mask wrong");
  ring_pon_a: assert property (ring_fall_s |=> pon_req_o)
    else $error("ring switch-on missing");
  wake_pon_a: assert property (wake_evt_i && pon_mask_o[1] &&
    !unit_on_i |=> pon_req_o)
    else $error("wake switch-on missing");
  no_pon_a: assert property (wake_evt_i && pon_mask_o[1:0] == 2'h0
    |=> !pon_req_o)
    else $error("switch-on not allowed");
  warn_beep_a: assert property (warn_start_s |=> beep_o)
    else $error("warning beep missing");
  chime_beep_a: assert property (hour_tick_i && pon_mask_o[3] &&
    unit_on_i |=> beep_o)
    else $error("chime missing");
  main_low_a: assert property (main_volt_o < 8'hAF |=> main_low_o)
    else $error("main low missing");
  main_ok_a: assert property (main_volt_o > 8'hBE |=> !main_low_o)
    else $error("main low stuck");
  main_band_a: assert property (main_volt_o >= 8'hAF &&
    main_volt_o <= 8'hBE |=> $stable(main_low_o))
    else $error("hysteresis broken");
  per_low_a: assert property (1'h1 |=> per_low_o ==
    ($past(per_volt_o) < 8'hA8))
    else $error("periph low wrong");
  volt_pass_a: assert property (!$past(rst_i) |->
    ain_volt_o == $past(ain_adc_i) && main_volt_o == $past(main_adc_i))
    else $error("voltage byte wrong");
endmodule
